// ### include/gci_pkg.sv
// package: constants and carriers for the global cache / tlb invalidate block
`default_nettype none
package gci_pkg;
  // ****************************************************************
  // widths and counts
  // ****************************************************************
  localparam int GCI_MAP_TAG_W   = 16;  // memory map tag width, above 10
  localparam int GCI_LEGACY_TAG_W = 10; // legacy tag incl. extension
  localparam int GCI_PP_W        = 19;  // page pair number, bits 31..13
  localparam int GCI_PP_LSB      = 13;  // address bit 13 = register bit 13
  localparam int GCI_SEL_W       = 4;   // single cache selector width
  localparam int GCI_LINES       = 16;  // lines in local icache model
  localparam int GCI_TLB_N       = 8;   // translation entries
  localparam int GCI_TLB_IDX_W   = 3;   // entry index width
  localparam logic [7:0] GCI_SYNC_STYPE = 8'h14; // ordering barrier subtype
  // support field encodings
  localparam logic [1:0] GCI_SUP_FULL = 2'h3;    // cache and tlb supported
  // tlb invalidate types
  localparam logic [1:0] GCI_T_ALL   = 2'h0;     // whole buffer
  localparam logic [1:0] GCI_T_VA    = 2'h1;     // by address, tag global
  localparam logic [1:0] GCI_T_TAG   = 2'h2;     // by tag
  localparam logic [1:0] GCI_T_VATAG = 2'h3;     // by address and tag
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic {GCI_OP_ICACHE, GCI_OP_TLB} gci_op_e;
  // broadcast message to remote cores
  typedef struct packed {
    gci_op_e                   op;       // operation kind
    logic                      all;      // all caches
    logic [GCI_SEL_W-1:0]      sel;      // single cache selector
    logic [GCI_PP_W-1:0]       page_pair; // page pair number
    logic [GCI_MAP_TAG_W-1:0]  map_tag;  // memory map tag
    logic [1:0]                ttype;    // tlb invalidate type
  } gci_msg_s;
  // issued request from the pipeline
  typedef struct packed {
    gci_op_e                   op;       // operation kind
    logic                      src_zero; // source register field is zero
    logic [31:0]               src_val;  // source register value
    logic [1:0]                ttype;    // tlb type field
  } gci_req_s;
  // one translation entry tag
  typedef struct packed {
    logic                      valid;    // entry valid
    logic                      is_global; // global bit
    logic [GCI_PP_W-1:0]       page_pair; // page pair number
    logic [GCI_PP_W-1:0]       mask;     // page mask on page pair
    logic [GCI_MAP_TAG_W-1:0]  map_tag;  // memory map tag
  } gci_tlbe_s;
endpackage : gci_pkg
`default_nettype wire

// ### rtl/gci_tlb_match.sv
// entry match logic for one translation invalidation
`default_nettype none
module gci_tlb_match
  import gci_pkg::*;
(
  // entry and its index
  input  wire gci_pkg::gci_tlbe_s            entry,
  input  wire logic [GCI_TLB_IDX_W-1:0]      idx,
  input  wire logic [GCI_TLB_IDX_W-1:0]      wired,
  // message to apply
  input  wire gci_pkg::gci_msg_s             msg,
  // result
  output logic                               kill
);
  logic va_m;   // address match under mask
  logic tag_m;  // tag match
  logic wired_e; // entry is wired

  // ****************************************************************
  // compare
  // ****************************************************************
  always_comb begin
    va_m    = ((entry.page_pair & ~entry.mask) ==
               (msg.page_pair & ~entry.mask));
    tag_m   = (entry.map_tag == msg.map_tag);
    wired_e = (idx <= wired);
    unique case (msg.ttype)
      GCI_T_ALL:   kill = !wired_e;
      GCI_T_VA:    kill = va_m;
      GCI_T_TAG:   kill = tag_m && !entry.is_global;
      default:     kill = va_m && (entry.is_global || tag_m);
    endcase
  end
endmodule // gci_tlb_match
`default_nettype wire

// ### rtl/gci_top.sv
// global instruction cache and translation invalidate engine
//
// What this block does
// - zero field: invalidate all remote and local
// - nonzero: invalidate one cache selected by bits
// - completion seen only through barrier 0x14
// - barrier done means prior invalidations visible
// - no send before prior reaches ordering point
// - invalidate is not a hazard barrier
// - locked cache lines stay valid
// - cache op needs support 1x, checked first
// - coprocessor disabled raises unusable, no action
// - single processor: local only, no messages
// - cover all software-coherent icache levels
// - remote stream synced when barrier completes
// - tlb op: address from register, tag from coprocessor
// - address is page pair, bit 13 aligned
// - all and tag types ignore register
// - map tag wider than ten-bit legacy tag
// - type 00 whole, 01 by address global
// - type 10 by tag, 11 address and tag
// - global entries skip tag compare
// - whole-buffer spares wired; others hit wired
// - tlb op needs support 11 and tag enable
`default_nettype none
module gci_top (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  // request from the pipeline
  input  wire logic                          req_valid,
  input  wire gci_pkg::gci_req_s             req,
  output logic                               req_ready,
  // configuration bits
  input  wire logic [1:0]                    global_invalidate_support_field,
  input  wire logic                          map_tag_enable_bit,
  input  wire logic                          cop0_enabled,
  input  wire logic                          single_processor,
  input  wire logic [gci_pkg::GCI_MAP_TAG_W-1:0] memory_map_tag,
  input  wire logic [gci_pkg::GCI_TLB_IDX_W-1:0] wired_limit,
  input  wire logic [gci_pkg::GCI_SEL_W-1:0] local_core_id,
  // exceptions
  output logic                               exc_reserved,
  output logic                               exc_cop_unusable,
  // ordering barrier
  input  wire logic                          sync_valid,
  input  wire logic [7:0]                    sync_stype,
  output logic                               sync_done,
  // icache line control from the cache
  input  wire logic [gci_pkg::GCI_LINES-1:0] line_lock,
  output logic [gci_pkg::GCI_LINES-1:0]      line_valid,
  input  wire logic [gci_pkg::GCI_LINES-1:0] line_fill,
  // translation buffer view
  input  wire gci_pkg::gci_tlbe_s [gci_pkg::GCI_TLB_N-1:0] tlb_load,
  input  wire logic [gci_pkg::GCI_TLB_N-1:0] tlb_load_en,
  output logic [gci_pkg::GCI_TLB_N-1:0]      tlb_valid,
  // interconnect
  output logic                               msg_valid,
  output gci_pkg::gci_msg_s                  msg,
  input  wire logic                          msg_ready,
  input  wire logic                          ord_point,
  input  wire logic                          remote_ack
);
  import gci_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum {GCI_IDLE, GCI_LOCAL, GCI_WAIT_ORD, GCI_SEND} gci_state_e;
  gci_state_e                 st_r;        // engine state
  gci_msg_s                   cur_r;       // message being handled
  logic                       remote_r;    // remote send needed
  logic                       local_r;     // local work needed
  logic                       ord_pend_r;  // prior send not yet ordered
  logic [7:0]                 ack_pend_r;  // remote acks outstanding
  logic                       sync_wait_r; // barrier waiting
  gci_tlbe_s [GCI_TLB_N-1:0]  tlb_r;       // translation tags
  logic [GCI_TLB_N-1:0]       kill;        // per-entry match
  logic                       is_ic;       // request is cache op
  logic                       ok_ic;       // cache op supported
  logic                       ok_tlb;      // tlb op supported
  logic                       sup_full;    // support field is 11
  logic                       ack_sync [3]; // remote ack synchroniser
  logic                       ack_ev;      // one ack
  logic                       ack_lvl_r;   // settled ack level

  // remote acks come from another domain: three flops; a level counts
  // once the second and third agree, each settled rise is one ack
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_sync[0] <= 1'b0;
      ack_sync[1] <= 1'b0;
      ack_sync[2] <= 1'b0;
      ack_lvl_r   <= 1'b0;
    end else begin
      ack_sync[0] <= remote_ack;
      ack_sync[1] <= ack_sync[0];
      ack_sync[2] <= ack_sync[1];
      if (ack_sync[1] == ack_sync[2])
        ack_lvl_r <= ack_sync[2];
    end
  end
  assign ack_ev = ack_sync[1] && ack_sync[2] && !ack_lvl_r; // settled rise

  // ****************************************************************
  // decode and checks
  // ****************************************************************
  always_comb begin
    is_ic    = (req.op == GCI_OP_ICACHE);
    ok_ic    = global_invalidate_support_field[1];
    sup_full = (global_invalidate_support_field == GCI_SUP_FULL);
    ok_tlb   = sup_full && map_tag_enable_bit;
  end

  // selector in the low source bits names this core
  function automatic logic names_self(input logic [31:0]          v,
                                      input logic [GCI_SEL_W-1:0] id);
    return (v[GCI_SEL_W-1:0] == id);
  endfunction

  // exceptions: support check before coprocessor check
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      exc_reserved     <= 1'b0;
      exc_cop_unusable <= 1'b0;
    end else begin
      exc_reserved     <= 1'b0;
      exc_cop_unusable <= 1'b0;
      if (req_valid && req_ready) begin
        // support, then coprocessor access, then tag enable
        if (is_ic ? !ok_ic : !sup_full)
          exc_reserved <= 1'b1;
        else if (!cop0_enabled)
          exc_cop_unusable <= 1'b1;
        else if (!is_ic && !map_tag_enable_bit)
          exc_reserved <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // engine
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r      <= GCI_IDLE;
      cur_r     <= '0;
      remote_r  <= 1'b0;
      local_r   <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      case (st_r)
        GCI_IDLE: begin
          // ready registered beside the state; no hazard stall for op
          req_ready <= 1'b1;
          if (req_valid && req_ready && cop0_enabled &&
              (is_ic ? ok_ic : ok_tlb)) begin
            cur_r.op      <= req.op;
            cur_r.all     <= req.src_zero;
            cur_r.sel     <= req.src_val[GCI_SEL_W-1:0];
            // page pair ignored for all and tag types
            cur_r.page_pair <= (req.ttype[0]) ?
                               req.src_val[31:GCI_PP_LSB] : '0;
            cur_r.map_tag <= memory_map_tag;
            cur_r.ttype   <= req.ttype;
            // local work: tlb always, cache when all or selected self
            local_r  <= !is_ic || req.src_zero ||
                        names_self(req.src_val, local_core_id);
            remote_r <= !single_processor && (!is_ic || req.src_zero ||
                        !names_self(req.src_val, local_core_id));
            req_ready <= 1'b0;
            st_r     <= GCI_LOCAL;
          end
        end
        GCI_LOCAL: begin
          // local invalidate applied this cycle
          st_r      <= remote_r ? GCI_WAIT_ORD : GCI_IDLE;
          req_ready <= !remote_r;
        end
        GCI_WAIT_ORD: begin
          if (!ord_pend_r)
            st_r <= GCI_SEND;
        end
        GCI_SEND: begin
          if (msg_ready) begin
            st_r      <= GCI_IDLE;
            req_ready <= 1'b1;
          end
        end
        default: begin
          st_r      <= GCI_IDLE;
          req_ready <= 1'b0;
        end
      endcase
    end
  end

  // broadcast port
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      msg_valid <= 1'b0;
      msg       <= '0;
    end else begin
      msg_valid <= (st_r == GCI_WAIT_ORD && !ord_pend_r) ||
                   (st_r == GCI_SEND && !msg_ready);
      msg       <= cur_r;
    end
  end

  // ordering point tracking: set on send wins over clear
  always_ff @(posedge mclk) begin
    if (sys_rst)
      ord_pend_r <= 1'b0;
    else if (msg_valid && msg_ready)
      ord_pend_r <= 1'b1;
    else if (ord_point)
      ord_pend_r <= 1'b0;
  end

  // remote acknowledgements outstanding
  always_ff @(posedge mclk) begin
    if (sys_rst)
      ack_pend_r <= 8'h00;
    else
      ack_pend_r <= ack_pend_r + {7'h00, msg_valid && msg_ready}
                    - {7'h00, ack_ev && (ack_pend_r != 8'h00)};
  end

  // ****************************************************************
  // local icache valid bits: whole level cleared, locked kept
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (sys_rst)
      line_valid <= '0;
    else if (st_r == GCI_LOCAL && local_r && cur_r.op == GCI_OP_ICACHE)
      // a fill landing in the same cycle wins over the clear
      line_valid <= (line_valid & line_lock) | line_fill;
    else
      line_valid <= line_valid | line_fill;
  end

  // ****************************************************************
  // local translation buffer
  // ****************************************************************
  for (genvar i = 0; i < GCI_TLB_N; i++) begin : g_tlb
    gci_tlb_match u_match (
      .entry (tlb_r[i]),
      .idx   (GCI_TLB_IDX_W'(i)),
      .wired (wired_limit),
      .msg   (cur_r),
      .kill  (kill[i])
    );
    always_ff @(posedge mclk) begin
      if (sys_rst)
        tlb_r[i] <= '0;
      else if (tlb_load_en[i])
        tlb_r[i] <= tlb_load[i];
      else if (st_r == GCI_LOCAL && cur_r.op == GCI_OP_TLB && kill[i])
        tlb_r[i].valid <= 1'b0;
    end
    always_ff @(posedge mclk) begin
      if (sys_rst)
        tlb_valid[i] <= 1'b0;
      else
        tlb_valid[i] <= tlb_r[i].valid;
    end
  end

  // ****************************************************************
  // ordering barrier: done only when all local and remote work ended
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_wait_r <= 1'b0;
      sync_done   <= 1'b0;
    end else begin
      sync_done <= 1'b0;
      if (sync_valid && sync_stype == GCI_SYNC_STYPE)
        sync_wait_r <= 1'b1;
      else if (sync_wait_r && st_r == GCI_IDLE && !req_valid &&
               !ord_pend_r && ack_pend_r == 8'h00) begin
        sync_wait_r <= 1'b0;
        sync_done   <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_ri_priority: assert property (@(posedge mclk) disable iff (sys_rst)
    (req_valid && req_ready && is_ic && !ok_ic) |=>
      exc_reserved && !exc_cop_unusable)
    else $error("reserved check lost priority");
  a_cu_noaction: assert property (@(posedge mclk) disable iff (sys_rst)
    (req_valid && req_ready && !cop0_enabled) |=> st_r == GCI_IDLE)
    else $error("invalidate started without coprocessor access");
  a_tlb_ri: assert property (@(posedge mclk) disable iff (sys_rst)
    (req_valid && req_ready && !is_ic && cop0_enabled &&
     !map_tag_enable_bit) |=> exc_reserved)
    else $error("tlb op without tag enable not refused");
  a_single_nomsg: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r == GCI_LOCAL && single_processor) |=> st_r == GCI_IDLE)
    else $error("single processor went remote");
  a_order_send: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r == GCI_WAIT_ORD && ord_pend_r) |=> !msg_valid)
    else $error("sent before ordering point");
  a_sync_pend: assert property (@(posedge mclk) disable iff (sys_rst)
    sync_done |-> $past(ack_pend_r) == 8'h00 && !$past(ord_pend_r))
    else $error("barrier done with work outstanding");
  a_lock_kept: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r == GCI_LOCAL && local_r && cur_r.op == GCI_OP_ICACHE) |=>
      line_valid == (($past(line_valid) & $past(line_lock))
                     | $past(line_fill)))
    else $error("icache invalidate wrong");
  a_msg_fields: assert property (@(posedge mclk) disable iff (sys_rst)
    msg_valid |-> st_r == GCI_SEND && msg == cur_r)
    else $error("message fields wrong");
endmodule // gci_top
`default_nettype wire

// ### tb/gci_remote_model.sv
// remote cores on the interconnect: accept, order, acknowledge
`default_nettype none
module gci_remote_model
  import gci_pkg::*;
(
  // clock, reset, pacing
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              slow,
  // interconnect
  input  wire logic              msg_valid,
  input  wire gci_pkg::gci_msg_s msg,
  output var  logic              msg_ready,
  output var  logic              ord_point,
  output var  logic              remote_ack,
  // observation
  output var  gci_pkg::gci_msg_s last_msg,
  output var  int                n_taken,
  output var  int                n_acked,
  output var  logic              ord_viol
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;  // cycles since the last take, 0 when idle
  int w;    // cycles the offered message has waited
  int ot;   // cycle of the ordering point after a take
  assign ot = slow ? 5 : 1;
  // ****
  // one message at a time, ack edge per message
  // ****
  always @(posedge mclk) begin
    // one pulse, ot cycles after a take
    ord_point <= !sys_rst && cnt == ot;
    if (sys_rst) begin
      msg_ready  <= 1'b0;
      remote_ack <= 1'b0;
      n_taken    <= 0;
      n_acked    <= 0;
      ord_viol   <= 1'b0;
      cnt        <= 0;
      w          <= 0;
    end else if (msg_valid && msg_ready) begin
      last_msg  <= msg;
      n_taken   <= n_taken + 1;
      msg_ready <= 1'b0;
      cnt       <= 1;
      w         <= 0;
    end else if (cnt != 0) begin
      cnt <= (cnt == 12) ? 0 : cnt + 1;
      // a new message before the ordering point is a fault
      if (msg_valid && cnt <= ot) ord_viol <= 1'b1;
      if (cnt == ot + 1) begin
        remote_ack <= 1'b1;
        n_acked    <= n_acked + 1;
      end
      if (cnt == ot + 5) remote_ack <= 1'b0;
    end else begin
      // slow mode stalls the offer three cycles
      w         <= msg_valid ? w + 1 : 0;
      msg_ready <= msg_valid && (!slow || w >= 3);
    end
  end
endmodule // gci_remote_model
`default_nettype wire

// ### tb/gci_top_tb.sv
// self-checking bench for the global invalidate engine
`default_nettype none
module gci_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gci_pkg::*;
  localparam logic [18:0] VT = 19'h12345;  // page pair under test
  logic mclk, sys_rst, req_valid, req_ready, map_en, cop0_en, single_p;
  logic exc_rsv, exc_cpu, sync_valid, sync_done, slow, ord_viol;
  logic msg_valid, msg_ready, ord_point, remote_ack;
  logic [1:0] sup, exc_seen;
  logic [7:0] sync_stype;
  logic [GCI_MAP_TAG_W-1:0] mmap;
  logic [2:0] wired;
  logic [3:0] core_id;
  logic [GCI_LINES-1:0] lock, lvalid, fill;
  logic [GCI_TLB_N-1:0] tload_en, tvalid;
  logic [31:0] va;
  logic [5:0] e;
  gci_tlbe_s [GCI_TLB_N-1:0] tload;
  gci_req_s req;
  gci_msg_s msg, last_msg;
  int n_taken, n_acked, cyc = 0, err_total = 0, tests_run = 0;
  // surviving entries per type, worked by hand for ent() below
  logic [7:0] tlb_exp [4] = '{8'h03, 8'h15, 8'hF3, 8'h17};
  // error cases: op, support, cop0, tag enable, reserved expected
  logic [5:0] exc_tab [7] = '{6'h0B, 6'h12, 6'h37, 6'h3D, 6'h3A, 6'h07,
                              6'h38};
  gci_top dut (.mclk(mclk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready),
    .global_invalidate_support_field(sup), .map_tag_enable_bit(map_en),
    .cop0_enabled(cop0_en), .single_processor(single_p),
    .memory_map_tag(mmap), .wired_limit(wired), .local_core_id(core_id),
    .exc_reserved(exc_rsv), .exc_cop_unusable(exc_cpu),
    .sync_valid(sync_valid), .sync_stype(sync_stype),
    .sync_done(sync_done), .line_lock(lock), .line_valid(lvalid),
    .line_fill(fill), .tlb_load(tload), .tlb_load_en(tload_en),
    .tlb_valid(tvalid), .msg_valid(msg_valid), .msg(msg),
    .msg_ready(msg_ready), .ord_point(ord_point), .remote_ack(remote_ack));
  gci_remote_model far (.mclk(mclk), .sys_rst(sys_rst), .slow(slow),
    .msg_valid(msg_valid), .msg(msg), .msg_ready(msg_ready),
    .ord_point(ord_point), .remote_ack(remote_ack), .last_msg(last_msg),
    .n_taken(n_taken), .n_acked(n_acked), .ord_viol(ord_viol));
  // ****
  // clock, timeout, reporting
  // ****
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic chk(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // access tasks
  // ****
  // hold the request until taken, then catch any exception pulse
  task automatic issue(input gci_op_e op, input logic [31:0] src,
                       input logic [1:0] t);
    int n;
    n = 0;
    req = '{op: op, src_zero: (src == 32'h0), src_val: src, ttype: t};
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(n < 100, "request never taken");
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    exc_seen = {exc_rsv, exc_cpu};
    @(posedge mclk);
    #1;
    exc_seen |= {exc_rsv, exc_cpu};
  endtask
  // one barrier; completion only for the right subtype, after acks
  task automatic barrier(input logic [7:0] st);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    sync_stype = st;
    sync_valid = 1'b1;
    @(posedge mclk);
    #1;
    sync_valid = 1'b0;
    while (!seen && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
      seen = (sync_done === 1'b1);
    end
    chk(seen === (st == GCI_SYNC_STYPE), "barrier completion");
    chk(n_acked == n_taken, "barrier ahead of remote acks");
  endtask
  task automatic refill();
    fill = '1;
    @(posedge mclk);
    #1;
    fill = '0;
  endtask
  // entry i: bit0 address hit, bit1 tag hit, bit2 global, 6 masked
  function automatic gci_tlbe_s ent(input int i);
    gci_tlbe_s x;
    x.valid = 1'b1;
    x.is_global = (i >= 4);
    x.mask = (i == 6) ? 19'h3 : 19'h0;
    x.page_pair = (i % 2 == 1) ? VT :
                  ((i == 6) ? VT ^ 19'h2 : VT + 19'h100);
    x.map_tag = ((i / 2) % 2 == 1) ? 16'hABCD : 16'h0011;
    return x;
  endfunction
  task automatic tlb_fill();
    for (int i = 0; i < GCI_TLB_N; i++) tload[i] = ent(i);
    tload_en = '1;
    @(posedge mclk);
    #1;
    tload_en = '0;
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    sup = 2'h3;
    map_en = 1'b1;
    cop0_en = 1'b1;
    single_p = 1'b0;
    mmap = 16'hABCD;
    wired = 3'h1;
    core_id = 4'h2;
    sync_valid = 1'b0;
    sync_stype = 8'h00;
    lock = 16'h00F0;
    fill = '0;
    tload = '0;
    tload_en = '0;
    slow = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    chk(lvalid === '0 && tvalid === '0 && msg_valid === 1'b0, "reset");
    @(posedge mclk);
    #1;
    chk(req_ready === 1'b1 && sync_done === 1'b0, "ready after reset");
    // all caches: local cleared except locked lines, one broadcast
    refill();
    issue(GCI_OP_ICACHE, 32'h0, 2'h0);
    barrier(GCI_SYNC_STYPE);
    chk(lvalid === 16'h00F0, "locked lines");
    chk(n_taken == 1 && last_msg.all === 1'b1, "broadcast all");
    // selector naming this core: local only, no message
    refill();
    issue(GCI_OP_ICACHE, 32'hFFFF_FFF2, 2'h0);
    barrier(GCI_SYNC_STYPE);
    chk(lvalid === 16'h00F0 && n_taken == 1, "local select");
    // two remote selects back to back against a slow far side
    slow = 1'b1;
    refill();
    issue(GCI_OP_ICACHE, 32'h0000_0005, 2'h0);
    issue(GCI_OP_ICACHE, 32'h0000_0007, 2'h0);
    barrier(GCI_SYNC_STYPE);
    chk(lvalid === '1 && n_taken == 3, "remote select");
    chk(last_msg.sel === 4'h7 && last_msg.all === 1'b0, "sel");
    chk(ord_viol === 1'b0, "sent before ordering point");
    barrier(8'h04);
    // single processor: local only
    slow = 1'b0;
    single_p = 1'b1;
    issue(GCI_OP_ICACHE, 32'h0, 2'h0);
    barrier(GCI_SYNC_STYPE);
    chk(lvalid === 16'h00F0 && n_taken == 3, "single core");
    single_p = 1'b0;
    // refused requests: right exception, nothing touched
    refill();
    tlb_fill();
    foreach (exc_tab[k]) begin
      e = exc_tab[k];
      sup = e[4:3];
      cop0_en = e[2];
      map_en = e[1];
      issue(gci_op_e'(e[5]), 32'h0000_2000, GCI_T_ALL);
      chk(exc_seen === {e[0], !e[0]}, "exception kind");
    end
    sup = 2'h3;
    cop0_en = 1'b1;
    map_en = 1'b1;
    barrier(GCI_SYNC_STYPE);
    chk(lvalid === '1 && tvalid === '1 && n_taken == 3, "no act");
    // every translation type, local entries and broadcast fields
    for (int t = 0; t < 4; t++) begin
      tlb_fill();
      va = (t % 2 == 1) ? {VT, 13'h1ABC} : 32'hFFFF_FFFF;
      issue(GCI_OP_TLB, va, 2'(t));
      barrier(GCI_SYNC_STYPE);
      chk(tvalid === tlb_exp[t], "tlb entries");
      chk(last_msg.op === GCI_OP_TLB && last_msg.ttype === 2'(t) &&
          last_msg.map_tag === mmap, "tlb message");
      chk(last_msg.page_pair === ((t % 2 == 1) ? VT : 19'h0),
          "page pair");
    end
    wrap_up();
  end
endmodule // gci_top_tb
`default_nettype wire
